// >>> dv/rsfc_chk.sv
// port checker for the reset controller
`timescale 1ns/100ps
`default_nettype none
`include "rsfc_consts.svh"
module rsfc_chk #(
  parameter int UV_MIN_CYC = `RSFC_UV_MIN_CYC
)(
  // clock and sources
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_external_reset_line_n,
  input wire logic i_uv_low,
  input wire logic i_uv_enable,
  input wire logic i_wdt_timeout,
  input wire logic i_powered_down,
  // reset actions
  input wire logic o_core_reset,
  input wire logic o_clr_pc,
  input wire logic o_clr_sp,
  input wire logic o_clr_wdt,
  input wire logic o_int_off,
  input wire logic o_tmr_off,
  input wire logic o_ports_in,
  input wire logic [7:0] o_port_load
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // consecutive cycles of an enabled low supply, as the pins show them
  int uv_run;
  always @(posedge i_clk)
    uv_run <= (i_reset || !(i_uv_enable && i_uv_low)) ? 0 : uv_run + 1;
  ////////////////////////////////////////////////////////////////
  property p_ext;
    $fell(i_external_reset_line_n) |-> ##[1:5] o_core_reset;
  endproperty
  a_ext: assert property (p_ext) else $error("line low, no reset");
  // three sync stages, the qualifying count, then the state edge
  property p_uv;
    uv_run >= UV_MIN_CYC + 4 |-> o_core_reset;
  endproperty
  a_uv: assert property (p_uv) else $error("low supply, no reset");
  property p_wdn;
    !i_powered_down && $rose(i_wdt_timeout) |-> ##[1:8] o_core_reset;
  endproperty
  a_wdn: assert property (p_wdn) else $error("timeout, no reset");
  property p_pdw;
    i_powered_down && $rose(i_wdt_timeout) |-> ##[1:8] (o_clr_pc && o_clr_sp && !o_ports_in);
  endproperty
  a_pdw: assert property (p_pdw) else $error("halted timeout wrong");
  property p_ctl;
    o_core_reset |-> o_int_off && o_clr_wdt && o_tmr_off && o_ports_in && o_clr_pc;
  endproperty
  a_ctl: assert property (p_ctl) else $error("reset actions missing");
  property p_load;
    o_ports_in |-> o_port_load == 8'hff;
  endproperty
  a_load: assert property (p_load) else $error("port load wrong");
  property p_sp;
    o_clr_pc |-> o_clr_sp;
  endproperty
  a_sp: assert property (p_sp) else $error("stack not reset");
  property p_start;
    !i_external_reset_line_n [*4] ##1 i_external_reset_line_n |-> o_core_reset [*8];
  endproperty
  a_start: assert property (p_start) else $error("start delay short");
endmodule
bind rsfc_reset_ctrl rsfc_chk #(.UV_MIN_CYC(UV_MIN_CYC)) u_chk (.*);
`default_nettype wire

// >>> dv/rsfc_ext_switch.sv
// reset switch with rc network on the reset line
`timescale 1ns/100ps
`default_nettype none
module rsfc_ext_switch #(parameter int RC_CYC = 5) (
  // clock and switch
  input wire logic i_clk,
  input wire logic i_press,
  // pulled-up reset line
  output logic o_line_n
);
  int chg = 0;
  initial o_line_n = 1'b1;
  // slow rc charge keeps the line low after release
  always @(posedge i_clk)
  begin
    chg <= i_press ? 0 : (chg < RC_CYC ? chg + 1 : chg);
    o_line_n <= !i_press && chg >= RC_CYC;
  end
endmodule
`default_nettype wire

// >>> dv/rsfc_reset_ctrl_tb.sv
// self-checking bench for the reset controller
`timescale 1ns/100ps
`default_nettype none
module rsfc_reset_ctrl_tb;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d, x; logic ex;} rsfc_row_s;
  // short delays keep the run small
  localparam int STARTUP = 8, UV_MIN = 4, RC = 5;
  logic i_clk = 0, i_reset = 1, press = 0, uv = 0, wdt = 0, pd = 0, en = 1;
  logic [1:0] thr = 2'h2, uvl;
  logic psel = 0, pen = 0, pw = 0, e, line_n, prdy, perr, crst, slow, rc;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, r, prd;
  logic [7:0] pld;
  int err_count = 0, cmp_count = 0, cyc = 0, n;
  rsfc_row_s rows [6] = '{'{1'b1, 12'h004, 32'h3, 32'h0, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h3, 1'b0}, '{1'b1, 12'h000, 32'h3f, 32'h0, 1'b0},
    '{1'b0, 12'h000, 32'h0, 32'hf, 1'b0}, '{1'b0, 12'h008, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h00c, 32'h0, 32'h0, 1'b1}};
  rsfc_ext_switch #(.RC_CYC(RC)) sw (.i_clk(i_clk), .i_press(press), .o_line_n(line_n));
  rsfc_reset_ctrl #(.STARTUP_CYC(STARTUP), .UV_MIN_CYC(UV_MIN)) dut (.i_clk(i_clk),
    .i_reset(i_reset), .i_external_reset_line_n(line_n), .i_uv_low(uv), .i_wdt_timeout(wdt),
    .i_powered_down(pd), .i_uv_enable(en), .i_undervoltage_threshold(thr),
    .i_osc_is_rc(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .o_core_reset(crst), .o_clr_pc(), .o_clr_sp(), .o_clr_wdt(), .o_int_off(),
    .o_tmr_off(), .o_ports_in(), .o_port_load(pld), .o_sel_slow(slow), .o_sel_rc(rc),
    .o_uv_level(uvl));
  always #25 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, x);
    cmp_count++;
    if (g !== x)
    begin
      err_count++;
      $display("unexpected t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do @(posedge i_clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, m);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask
  // bounded wait, n counts the cycles taken
  task automatic wait_core(input logic v);
    n = 0;
    while (crst !== v && n < 200)
    begin
      @(posedge i_clk);
      n++;
    end
    chk(32'(crst), 32'(v));
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_core(1'b0);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(32'(e), 32'(rows[i].ex));
      if (!rows[i].w && !rows[i].ex) chk(r, rows[i].x);
    end
    repeat (2) @(posedge i_clk);
    chk(32'({slow, rc}), 32'h3);
    chk(32'(uvl), 32'h2);
    thr <= 2'h1;
    repeat (2) @(posedge i_clk);
    chk(32'(uvl), 32'h1);
    $display("registers done");
    wdt <= 1'b1;
    repeat (2) @(posedge i_clk);
    wdt <= 1'b0;
    wait_core(1'b1);
    chk(32'(pld), 32'hff);
    wait_core(1'b0);
    rdc(12'h008, 32'h3, 32'h7);
    rdc(12'h000, 32'h20, 32'h30);
    $display("watchdog done");
    press <= 1'b1;
    wait_core(1'b1);
    repeat (4) @(posedge i_clk);
    press <= 1'b0;
    wait_core(1'b0);
    chk(32'(n >= RC + STARTUP + 4 && n <= RC + STARTUP + 8), 32'h1);
    rdc(12'h008, 32'h1, 32'h7);
    rdc(12'h000, 32'h20, 32'h30);
    rdc(12'h004, 32'h0, 32'h3);
    $display("line reset done");
    pd <= 1'b1;
    wdt <= 1'b1;
    repeat (2) @(posedge i_clk);
    wdt <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk(32'(crst), 32'h0);
    pd <= 1'b0;
    rdc(12'h008, 32'h4, 32'h7);
    rdc(12'h000, 32'h30, 32'h30);
    $display("halted watchdog done");
    en <= 1'b0;
    uv <= 1'b1;
    repeat (UV_MIN + 10) @(posedge i_clk);
    chk(32'(crst), 32'h0);
    uv <= 1'b0;
    en <= 1'b1;
    repeat (4) @(posedge i_clk);
    uv <= 1'b1;
    repeat (2) @(posedge i_clk);
    uv <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk(32'(crst), 32'h0);
    uv <= 1'b1;
    wait_core(1'b1);
    uv <= 1'b0;
    wait_core(1'b0);
    rdc(12'h008, 32'h2, 32'h7);
    rdc(12'h000, 32'h30, 32'h30);
    $display("low supply done");
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_core(1'b0);
    rdc(12'h000, 32'h0, 32'h30);
    $display("power-on done");
    final_report();
  end
endmodule
`default_nettype wire

// >>> src/rsfc_consts.svh
// constants for the reset source and flag controller
// Summary of operation
// - External reset line low while running resets device; program counter goes to zero.
// - Enabled under-voltage monitor resets device when supply sits below threshold.
// - Under-voltage must persist beyond minimum duration; shorter dips are ignored.
// - Under-voltage threshold comes from fixed configuration options, not registers.
// - Watchdog timeout when running acts like external reset, sets timeout flag.
// - Watchdog timeout in power-down clears only PC and stack, sets both flags.
// - Power-on reset clears timeout and power-down flags.
// - External or under-voltage reset leaves both flags unchanged.
// - Reset disables all interrupts, global and individual enables.
// - Reset clears watchdog counter; counting resumes once reset is released.
// - Reset stops timer/event counters and clears the timer prescaler.
// - Reset loads all ones into port data and direction, except power-down timeout.
// - Reset returns stack pointer to top of stack, leaving call stack empty.
// - Option picks crystal or RC; slow-clock select bit picks 32768Hz clock.
// - After external reset release, wait a start-up delay before executing.
`ifndef RSFC_CONSTS_SVH
`define RSFC_CONSTS_SVH
`define RSFC_CLK_HZ 20000000
`define RSFC_UV_MIN_NS 120000
`define RSFC_UV_MIN_CYC ((`RSFC_UV_MIN_NS * (`RSFC_CLK_HZ / 1000000) + 999) / 1000)
`define RSFC_STARTUP_CYC 1024
`define RSFC_PORT_ONES 8'hff
`define RSFC_ADDR_STATUS 12'h000
`define RSFC_ADDR_MODE 12'h004
`define RSFC_ADDR_CAUSE 12'h008
`define RSFC_ST_TO_BIT 5
`define RSFC_ST_PD_BIT 4
`define RSFC_MODE_SLOW_BIT 0
`define RSFC_MODE_QOSC_BIT 1
`endif

// >>> src/rsfc_pkg.sv
// types for the reset source and flag controller
package rsfc_pkg;
  typedef enum logic [1:0] {
    RSFC_RUN = 2'b10,
    RSFC_HOLD = 2'b01,
    RSFC_START = 2'b11
  } rsfc_state_e;
  typedef enum logic [2:0] {
    RSFC_C_POR = 3'h0,
    RSFC_C_EXT = 3'h1,
    RSFC_C_UV = 3'h2,
    RSFC_C_WDN = 3'h3,
    RSFC_C_WDP = 3'h4
  } rsfc_cause_e;
  typedef struct packed {
    logic clr_pc;
    logic clr_sp;
    logic clr_wdt;
    logic int_off;
    logic tmr_off;
    logic ports_in;
  } rsfc_ctl_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rsfc_apb_s;
endpackage

// >>> src/rsfc_reset_ctrl.sv
// reset source merge, cause flags and clock select
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "rsfc_consts.svh"
module rsfc_reset_ctrl
  import rsfc_pkg::*;
#(
  parameter int STARTUP_CYC = `RSFC_STARTUP_CYC,
  parameter int UV_MIN_CYC = `RSFC_UV_MIN_CYC
)(
  // clock and power-on
  input wire logic i_clk,
  input wire logic i_reset,
  // reset sources
  input wire logic i_external_reset_line_n,
  input wire logic i_uv_low,
  input wire logic i_wdt_timeout,
  input wire logic i_powered_down,
  // configuration options
  input wire logic i_uv_enable,
  input wire logic [1:0] i_undervoltage_threshold,
  input wire logic i_osc_is_rc,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // reset actions
  output logic o_core_reset,
  output logic o_clr_pc,
  output logic o_clr_sp,
  output logic o_clr_wdt,
  output logic o_int_off,
  output logic o_tmr_off,
  output logic o_ports_in,
  output logic [7:0] o_port_load,
  // clock select and under-voltage level
  output logic o_sel_slow,
  output logic o_sel_rc,
  output logic [1:0] o_uv_level
);
  typedef struct packed {
    logic [2:0] ext_sync;
    logic [2:0] uv_sync;
    logic [2:0] wdt_sync;
    logic ext_q;
    logic wdt_q;
    logic [15:0] uv_cnt;
    logic [15:0] st_cnt;
    rsfc_state_e st;
    logic core_rst;
    rsfc_cause_e cause;
    logic to_flag;
    logic pd_flag;
    logic [3:0] status_low;
    logic [1:0] mode;
    rsfc_ctl_s ctl;
    logic [7:0] port_load;
    rsfc_apb_s apb;
    logic sel_slow;
    logic sel_rc;
    logic [1:0] uv_level;
  } rsfc_reg_s;

  rsfc_reg_s r;
  rsfc_reg_s next_r;
  logic ext_low;
  logic uv_low;
  logic wdt_ev;
  logic uv_fire;
  logic apb_acc;

  function automatic logic agree(input logic [2:0] s, input logic prev);
    // a change counts only when the last two stages agree
    agree = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r = r;
    next_r.ext_sync = {r.ext_sync[1:0], ~i_external_reset_line_n};
    next_r.uv_sync = {r.uv_sync[1:0], i_uv_low & i_uv_enable};
    next_r.wdt_sync = {r.wdt_sync[1:0], i_wdt_timeout};
    ext_low = agree(r.ext_sync, r.ext_q);
    uv_low = agree(r.uv_sync, r.uv_cnt != 16'h0000);
    wdt_ev = agree(r.wdt_sync, r.wdt_q) & ~r.wdt_q;
    next_r.ext_q = ext_low;
    next_r.wdt_q = agree(r.wdt_sync, r.wdt_q);
    // short dips never reach the limit, so they are ignored
    uv_fire = 1'b0;
    if (uv_low)
    begin
      if (r.uv_cnt < 16'(UV_MIN_CYC))
        next_r.uv_cnt = r.uv_cnt + 16'h0001;
      else
        uv_fire = 1'b1;
    end
    else
      next_r.uv_cnt = 16'h0000;
    // configuration options are latched straight from straps each cycle
    next_r.uv_level = i_undervoltage_threshold;
    next_r.sel_rc = i_osc_is_rc;
    next_r.sel_slow = r.mode[`RSFC_MODE_SLOW_BIT];
    next_r.ctl = '0;
    case (r.st)
      RSFC_RUN:
      begin
        if (ext_low || uv_fire)
        begin
          next_r.st = RSFC_HOLD;
          next_r.cause = ext_low ? RSFC_C_EXT : RSFC_C_UV;
        end
        else if (wdt_ev && i_powered_down)
        begin
          next_r.cause = RSFC_C_WDP;
          next_r.to_flag = 1'b1;
          next_r.pd_flag = 1'b1;
          next_r.ctl.clr_pc = 1'b1;
          next_r.ctl.clr_sp = 1'b1;
        end
        else if (wdt_ev)
        begin
          next_r.st = RSFC_HOLD;
          next_r.cause = RSFC_C_WDN;
          next_r.to_flag = 1'b1;
        end
      end
      RSFC_HOLD:
      begin
        next_r.ctl = '1;
        next_r.port_load = `RSFC_PORT_ONES;
        next_r.mode = 2'b00;
        next_r.st_cnt = 16'h0000;
        if (!ext_low && !uv_low)
          next_r.st = RSFC_START;
      end
      RSFC_START:
      begin
        // actions held through start-up; watchdog freed at release
        next_r.ctl = '1;
        next_r.ctl.clr_wdt = 1'b1;
        next_r.st_cnt = r.st_cnt + 16'h0001;
        if (ext_low || uv_fire)
          next_r.st = RSFC_HOLD;
        else if (r.st_cnt >= 16'(STARTUP_CYC - 1))
        begin
          next_r.st = RSFC_RUN;
          next_r.ctl = '0;
        end
      end
      default:
        next_r.st = RSFC_HOLD;
    endcase
    // actions rise with the core reset, never a cycle behind it
    if (next_r.st != RSFC_RUN)
      next_r.ctl = '1;
    next_r.core_rst = (next_r.st != RSFC_RUN);
    // apb slave: read data registered at setup, writes land at the access edge
    apb_acc = i_psel & i_penable;
    next_r.apb.pready = i_psel & ~r.apb.pready;
    next_r.apb.pslverr = 1'b0;
    next_r.apb.prdata = 32'h0000_0000;
    if (i_psel && !r.apb.pready)
    begin
      case (i_paddr)
        `RSFC_ADDR_STATUS:
          next_r.apb.prdata = {26'h0, r.to_flag, r.pd_flag, r.status_low};
        `RSFC_ADDR_MODE:
          next_r.apb.prdata = {30'h0, r.mode};
        `RSFC_ADDR_CAUSE:
          next_r.apb.prdata = {29'h0, r.cause};
        default:
          next_r.apb.pslverr = 1'b1;
      endcase
      if (i_pwrite)
        next_r.apb.prdata = 32'h0000_0000;
    end
    if (apb_acc && r.apb.pready && i_pwrite)
    begin
      // flags are read only; software owns the low bits
      if (i_paddr == `RSFC_ADDR_STATUS)
        next_r.status_low = i_pwdata[3:0];
      else if (i_paddr == `RSFC_ADDR_MODE && r.st == RSFC_RUN)
        next_r.mode = i_pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      r <= '0;
      r.st <= RSFC_HOLD;
      r.core_rst <= 1'b1;
      r.cause <= RSFC_C_POR;
      r.to_flag <= 1'b0;
      r.pd_flag <= 1'b0;
      r.ctl <= '1;
      r.port_load <= `RSFC_PORT_ONES;
      r.ext_sync <= 3'b000;
    end
    else
      r <= next_r;
  end

  assign o_prdata = r.apb.prdata;
  assign o_pready = r.apb.pready;
  assign o_pslverr = r.apb.pslverr;
  assign o_core_reset = r.core_rst;
  assign o_clr_pc = r.ctl.clr_pc;
  assign o_clr_sp = r.ctl.clr_sp;
  assign o_clr_wdt = r.ctl.clr_wdt;
  assign o_int_off = r.ctl.int_off;
  assign o_tmr_off = r.ctl.tmr_off;
  assign o_ports_in = r.ctl.ports_in;
  assign o_port_load = r.port_load;
  assign o_sel_slow = r.sel_slow;
  assign o_sel_rc = r.sel_rc;
  assign o_uv_level = r.uv_level;
endmodule
`default_nettype wire
